//--- pkg/sar_defines.svh
// timing counts, widths and bit layouts shared by both converter ends
// assumes inclusion by bare name from the package and the modules
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH
`define CODE_W 13
`define SIGN_BIT 12
`define CODE_MAX 14'sh0fff
`define CODE_MIN 14'sh3000
`define TEST_MASK 13'h006c
`define ACQ_CYCLES 7
`define AZ_CYCLES 26
`define CAL_CYCLES 1396
`define HOST_WR_LOW 3
`define HOST_CAL_LOW 3
`define HOST_RD_LOW 6
`define HOST_GUARD 8
`define HOST_SETTLE 5000
`endif

//--- pkg/sar_pkg.sv
// types shared by the device end and the host end of the converter port
// assumes the defines header is on the include path
`include "sar_defines.svh"
package sar_pkg;
  typedef logic signed [`CODE_W-1:0] code_type;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_CAL = 3'b001,
    DEV_AZ = 3'b010,
    DEV_ACQ = 3'b011,
    DEV_CONV = 3'b100
  } dev_state_type;
  typedef enum logic [2:0] {
    H_SETTLE = 3'b000,
    H_IDLE = 3'b001,
    H_START = 3'b010,
    H_WR_HOLD = 3'b011,
    H_CAL = 3'b100,
    H_WAIT_EOC = 3'b101,
    H_WAIT_INT = 3'b110,
    H_READ = 3'b111
  } host_state_type;
endpackage : sar_pkg

//--- pkg/sar_if.sv
// parallel control port between host and converter
// assumes one clock for both ends; undriven bus bits read high (pull-up)
`timescale 1ns/100ps
`include "sar_defines.svh"
interface sar_if (
  input wire logic ref_clk
);
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic cal_n;
  logic offset_null_request_n;
  logic eoc;
  logic int_n;
  logic [`CODE_W-1:0] bus_out;
  logic [`CODE_W-1:0] bus_oe_n;
  wire [`CODE_W-1:0] result_bus;
  genvar i;
  generate
    for (i = 0; i < `CODE_W; i++) begin : g_bus
      assign result_bus[i] = bus_oe_n[i] ? 1'b1 : bus_out[i];
    end
  endgenerate
  modport device (
    input cs_n,
    input wr_n,
    input rd_n,
    input cal_n,
    input offset_null_request_n,
    output eoc,
    output int_n,
    output bus_out,
    output bus_oe_n
  );
  modport host (
    output cs_n,
    output wr_n,
    output rd_n,
    output cal_n,
    output offset_null_request_n,
    input eoc,
    input int_n,
    input result_bus
  );
endinterface : sar_if

//--- rtl/sar_device.sv
// converter control sequencer: calibration, offset null, acquisition, sar
// assumes sample_code/offset_code come from the front end on ref_clk;
// rst_n stands in for power-up
// Function
// - write pulse with select starts plain conversion
// - offset-null low adds null cycle first
// - select and read low drive result
// - select and calibrate low: test outputs driven
// - host never enters test mode
// - new start resets logic, aborts conversion
// - start during sampling needs recalibration
// - calibration cannot be aborted once begun
// - power-up calibration of 1396 clocks
// - host recalibrates once after settling
// - calibration correction stored, applied every conversion
// - result saturates to -4096 .. 4095
// - hold command seven clocks after write rise
// - host nulls offset on temperature change
// - calibrate pulse with select, read, write high
// - conversion-active low during conversion and calibration
// - result-ready low on latch, high on read/start
// - offset null adds 26 clocks
`timescale 1ns/100ps
`include "sar_defines.svh"
module sar_device #(
  parameter int CAL_CYCLES = `CAL_CYCLES,
  parameter int ACQ_CYCLES = `ACQ_CYCLES,
  parameter int AZ_CYCLES = `AZ_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sar_if.device link,
  input wire sar_pkg::code_type sample_code,
  input wire sar_pkg::code_type offset_code,
  output logic track_enable
);
  import sar_pkg::*;

  dev_state_type state_reg;
  logic [10:0] cnt_reg;
  logic [3:0] bit_reg;
  logic az_reg;
  code_type corr_reg;
  code_type hold_reg;
  code_type trial_reg;
  code_type result_reg;
  logic done_reg;
  logic eoc_reg;
  logic int_n_reg;
  logic [`CODE_W-1:0] out_reg;
  logic [`CODE_W-1:0] oe_n_reg;
  logic track_reg;
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] prev_reg;

  logic cs_n_s;
  logic wr_n_s;
  logic rd_n_s;
  logic cal_n_s;
  logic az_n_s;
  logic start_low;
  logic start_rise;
  logic cal_fall;
  logic read_cond;
  logic test_cond;
  logic busy_cal;
  logic signed [`CODE_W:0] diff;
  code_type target;
  code_type test_val;

  // pins from the host are treated as foreign: two flops before use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= 5'h1f;
      sync_reg <= 5'h1f;
      prev_reg <= 5'h1f;
    end else begin
      meta_reg <= {link.cs_n, link.wr_n, link.rd_n, link.cal_n, link.offset_null_request_n};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign cs_n_s = sync_reg[4];
  assign wr_n_s = sync_reg[3];
  assign rd_n_s = sync_reg[2];
  assign cal_n_s = sync_reg[1];
  assign az_n_s = sync_reg[0];
  assign busy_cal = (state_reg == DEV_CAL);
  assign start_low = !cs_n_s && !wr_n_s && rd_n_s && cal_n_s;
  assign start_rise = !prev_reg[3] && wr_n_s && !cs_n_s && rd_n_s && cal_n_s;
  assign cal_fall = prev_reg[1] && !cal_n_s && cs_n_s;
  assign read_cond = !cs_n_s && !rd_n_s && wr_n_s && cal_n_s;
  assign test_cond = !cs_n_s && !cal_n_s && rd_n_s;

  // correction applied to the held sample, then clamped to the code span
  assign diff = {hold_reg[`SIGN_BIT], hold_reg} - {corr_reg[`SIGN_BIT], corr_reg};
  always_comb begin
    if (diff > `CODE_MAX) begin
      target = 13'h0fff;
    end else if (diff < `CODE_MIN) begin
      target = 13'h1000;
    end else begin
      target = diff[`CODE_W-1:0];
    end
  end
  assign test_val = trial_reg | code_type'(13'h0001 << bit_reg);

  // sequencing; calibration ignores every control input until it ends
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= DEV_CAL;
      cnt_reg <= 11'(CAL_CYCLES - 1);
      bit_reg <= 4'h0;
      az_reg <= 1'b0;
    end else begin
      case (state_reg)
        DEV_CAL: begin
          if (cnt_reg == 11'h000) begin
            state_reg <= DEV_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 11'h001;
          end
        end
        DEV_IDLE, DEV_AZ, DEV_ACQ, DEV_CONV: begin
          if (start_low) begin
            state_reg <= DEV_IDLE;
          end else if (cal_fall) begin
            state_reg <= DEV_CAL;
            cnt_reg <= 11'(CAL_CYCLES - 1);
          end else if (start_rise) begin
            az_reg <= !az_n_s;
            if (!az_n_s) begin
              state_reg <= DEV_AZ;
              cnt_reg <= 11'(AZ_CYCLES - 1);
            end else begin
              state_reg <= DEV_ACQ;
              cnt_reg <= 11'(ACQ_CYCLES - 1);
            end
          end else if (state_reg == DEV_AZ) begin
            if (cnt_reg == 11'h000) begin
              state_reg <= DEV_ACQ;
              cnt_reg <= 11'(ACQ_CYCLES - 1);
            end else begin
              cnt_reg <= cnt_reg - 11'h001;
            end
          end else if (state_reg == DEV_ACQ) begin
            if (cnt_reg == 11'h000) begin
              state_reg <= DEV_CONV;
              bit_reg <= 4'(`SIGN_BIT);
            end else begin
              cnt_reg <= cnt_reg - 11'h001;
            end
          end else if (state_reg == DEV_CONV) begin
            if (bit_reg == 4'h0) begin
              state_reg <= DEV_IDLE;
            end else begin
              bit_reg <= bit_reg - 4'h1;
            end
          end
        end
        default: begin
          state_reg <= DEV_IDLE;
        end
      endcase
    end
  end

  // corrections: full calibration and offset null both store the offset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      corr_reg <= 13'h0000;
    end else if (busy_cal && cnt_reg == 11'h000) begin
      corr_reg <= offset_code;
    end else if (state_reg == DEV_AZ && cnt_reg == 11'h000 && !start_low && !cal_fall) begin
      corr_reg <= offset_code;
    end
  end

  // hold command and successive approximation, sign decided first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_reg <= 13'h0000;
      trial_reg <= 13'h0000;
      result_reg <= 13'h0000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == DEV_ACQ && cnt_reg == 11'h000 && !start_low && !cal_fall) begin
        hold_reg <= sample_code;
        trial_reg <= 13'h0000;
      end else if (state_reg == DEV_CONV && !start_low && !cal_fall && !start_rise) begin
        if (bit_reg == 4'(`SIGN_BIT)) begin
          trial_reg <= {target[`SIGN_BIT], 12'h000};
        end else if (bit_reg == 4'h0) begin
          result_reg <= (test_val <= target) ? test_val : trial_reg;
          done_reg <= 1'b1;
        end else if (test_val <= target) begin
          trial_reg <= test_val;
        end
      end
    end
  end

  // status pins; a latch event beats a read that lands with it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eoc_reg <= 1'b0;
      int_n_reg <= 1'b1;
      track_reg <= 1'b0;
    end else begin
      eoc_reg <= !(state_reg == DEV_CAL || state_reg == DEV_CONV) || done_reg;
      track_reg <= (state_reg == DEV_ACQ);
      if (done_reg) begin
        int_n_reg <= 1'b0;
      end else if (read_cond || start_low || (cal_fall && !busy_cal)) begin
        int_n_reg <= 1'b1;
      end
    end
  end

  // output bus drive; test mode shows the three sequencer state bits and the null flag on four bits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_reg <= 13'h0000;
      oe_n_reg <= 13'h1fff;
    end else if (read_cond) begin
      out_reg <= result_reg;
      oe_n_reg <= 13'h0000;
    end else if (test_cond) begin
      out_reg <= {6'h00, state_reg[2], state_reg[1], 1'b0, state_reg[0], az_reg, 2'b00};
      oe_n_reg <= ~(`TEST_MASK);
    end else begin
      out_reg <= 13'h0000;
      oe_n_reg <= 13'h1fff;
    end
  end

  assign link.eoc = eoc_reg;
  assign link.int_n = int_n_reg;
  assign link.bus_out = out_reg;
  assign link.bus_oe_n = oe_n_reg;
  assign track_enable = track_reg;
endmodule : sar_device

//--- rtl/sar_host.sv
// host end: issues calibrate, start and read cycles on the control port
// assumes the device end on the same ref_clk; device pins synced anyway
`timescale 1ns/100ps
`include "sar_defines.svh"
module sar_host #(
  parameter int SETTLE_CYCLES = `HOST_SETTLE,
  parameter int WR_LOW = `HOST_WR_LOW,
  parameter int CAL_LOW = `HOST_CAL_LOW,
  parameter int RD_LOW = `HOST_RD_LOW,
  parameter int GUARD = `HOST_GUARD
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sar_if.host link,
  input wire logic start_req,
  input wire logic null_offset,
  input wire logic cal_req,
  input wire logic read_req,
  output logic ready,
  output logic result_strobe,
  output sar_pkg::code_type result_data
);
  import sar_pkg::*;

  host_state_type state_reg;
  logic [15:0] cnt_reg;
  logic [`CODE_W+1:0] meta_reg;
  logic [`CODE_W+1:0] sync_reg;
  logic cs_n_reg;
  logic wr_n_reg;
  logic rd_n_reg;
  logic cal_n_reg;
  logic az_n_reg;
  logic ready_reg;
  logic strobe_reg;
  code_type data_reg;
  logic eoc_s;
  logic int_n_s;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= 15'h7fff;
      sync_reg <= 15'h7fff;
    end else begin
      meta_reg <= {link.eoc, link.int_n, link.result_bus};
      sync_reg <= meta_reg;
    end
  end
  assign eoc_s = sync_reg[`CODE_W+1];
  assign int_n_s = sync_reg[`CODE_W];

  // select is never low while calibrate is low, so no test mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= H_SETTLE;
      cnt_reg <= 16'(SETTLE_CYCLES);
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      cal_n_reg <= 1'b1;
      az_n_reg <= 1'b1;
      ready_reg <= 1'b0;
      strobe_reg <= 1'b0;
      data_reg <= 13'h0000;
    end else begin
      strobe_reg <= 1'b0;
      if (cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      case (state_reg)
        H_SETTLE: begin
          if (cnt_reg == 16'h0000 && eoc_s) begin
            state_reg <= H_CAL;
            cal_n_reg <= 1'b0;
            cnt_reg <= 16'(CAL_LOW - 1);
          end
        end
        H_IDLE: begin
          if (cal_req) begin
            state_reg <= H_CAL;
            cal_n_reg <= 1'b0;
            cnt_reg <= 16'(CAL_LOW - 1);
            ready_reg <= 1'b0;
          end else if (start_req) begin
            state_reg <= H_START;
            cs_n_reg <= 1'b0;
            wr_n_reg <= 1'b0;
            az_n_reg <= !null_offset;
            cnt_reg <= 16'(WR_LOW - 1);
            ready_reg <= 1'b0;
          end else if (read_req) begin
            state_reg <= H_READ;
            cs_n_reg <= 1'b0;
            rd_n_reg <= 1'b0;
            cnt_reg <= 16'(RD_LOW - 1);
            ready_reg <= 1'b0;
          end
        end
        H_START: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= H_WR_HOLD;
            wr_n_reg <= 1'b1;
          end
        end
        H_WR_HOLD: begin
          state_reg <= H_WAIT_INT;
          cs_n_reg <= 1'b1;
          cnt_reg <= 16'(GUARD);
        end
        H_CAL: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= H_WAIT_EOC;
            cal_n_reg <= 1'b1;
            cnt_reg <= 16'(GUARD);
          end
        end
        H_WAIT_EOC: begin
          if (cnt_reg == 16'h0000 && eoc_s) begin
            state_reg <= H_IDLE;
            ready_reg <= 1'b1;
          end
        end
        H_WAIT_INT: begin
          // guard lets a stale ready from an unread result drain first
          if (cnt_reg == 16'h0000 && !int_n_s) begin
            state_reg <= H_IDLE;
            ready_reg <= 1'b1;
          end
        end
        H_READ: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= H_IDLE;
            cs_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            data_reg <= sync_reg[`CODE_W-1:0];
            strobe_reg <= 1'b1;
            ready_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.wr_n = wr_n_reg;
  assign link.rd_n = rd_n_reg;
  assign link.cal_n = cal_n_reg;
  assign link.offset_null_request_n = az_n_reg;
  assign ready = ready_reg;
  assign result_strobe = strobe_reg;
  assign result_data = data_reg;
endmodule : sar_host

//--- sim/sar_checker_sva.sv
// assertions on the control port joining the host end and converter end
// assumes one clock domain; inputs wired straight from the interface
`timescale 1ns/100ps
`include "sar_defines.svh"
module sar_checker_sva #(
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic cal_n,
  input wire logic offset_null_request_n,
  input wire logic eoc,
  input wire logic int_n,
  input wire logic [`CODE_W-1:0] bus_oe_n,
  input wire logic [`CODE_W-1:0] result_bus
);
  int low_cnt_reg;
  wire logic rd_cond = !cs_n && !rd_n && wr_n && cal_n;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // counts through reset too, so the power-up run is measured whole
  always_ff @(posedge ref_clk) begin
    if (eoc) begin
      low_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 1;
    end
  end
  property p_read_drive;
    rd_cond [*5] |-> bus_oe_n == '0;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("bus idle in read");
  property p_release;
    cs_n [*4] |-> &bus_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("bus driven unselected");
  property p_bus_stable;
    bus_oe_n == '0 && $past(bus_oe_n) == '0 |-> $stable(result_bus);
  endproperty
  a_bus_stable: assert property (p_bus_stable) else $error("bus moved in read");
  property p_latch;
    $fell(int_n) |-> eoc && !$past(eoc);
  endproperty
  a_latch: assert property (p_latch) else $error("ready without eoc rise");
  property p_read_clear;
    rd_cond [*5] |-> int_n;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left ready low");
  property p_start_clear;
    $rose(wr_n) && !cs_n |-> ##[0:3] int_n [*6];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start kept ready");
  property p_plain_len;
    $rose(wr_n) && !cs_n && offset_null_request_n |-> eoc [*8] ##[1:5] !eoc;
  endproperty
  a_plain_len: assert property (p_plain_len) else $error("bad acquisition");
  property p_null_len;
    $rose(wr_n) && !cs_n && !offset_null_request_n |-> eoc [*8] ##26 eoc ##[1:5] !eoc;
  endproperty
  a_null_len: assert property (p_null_len) else $error("bad null length");
  property p_cal_eoc;
    $fell(cal_n) && cs_n |-> ##[1:6] !eoc ##1 !eoc [*8];
  endproperty
  a_cal_eoc: assert property (p_cal_eoc) else $error("eoc high in cal");
  property p_low_len;
    $rose(eoc) |-> low_cnt_reg inside {[11:16]} || low_cnt_reg >= CAL_CYCLES - 4;
  endproperty
  a_low_len: assert property (p_low_len) else $error("eoc low run wrong");
endmodule : sar_checker_sva

//--- sim/tb_sar_adc_control_sequencer.sv
// bench: host end against device end, plus a bare device driven by hand
// assumes the package, interface and both ends compiled before it
`timescale 1ns/100ps
`include "sar_defines.svh"
module tb_sar_adc_control_sequencer;
  import sar_pkg::*;
  localparam int CAL = 40;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_req = 1'b0;
  logic null_offset = 1'b0;
  logic cal_req = 1'b0;
  logic read_req = 1'b0;
  logic ready;
  logic result_strobe;
  code_type result_data;
  code_type sample = '0;
  code_type offset = '0;
  code_type sample_b = '0;
  logic track_b;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int corr = 0;
  logic [31:0] lfsr = 32'h0598;
  always #4 ref_clk = ~ref_clk;
  sar_if link (.ref_clk(ref_clk));
  sar_if link_b (.ref_clk(ref_clk));
  sar_device #(.CAL_CYCLES(CAL)) u_sar_device (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .sample_code(sample), .offset_code(offset), .track_enable());
  sar_host #(.SETTLE_CYCLES(20)) u_sar_host (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link), .start_req(start_req), .null_offset(null_offset), .cal_req(cal_req),
    .read_req(read_req), .ready(ready), .result_strobe(result_strobe),
    .result_data(result_data));
  sar_device #(.CAL_CYCLES(CAL)) u_sar_device_b (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(link_b), .sample_code(sample_b), .offset_code(13'sh0005), .track_enable(track_b));
  sar_checker_sva #(.CAL_CYCLES(CAL)) u_sar_checker_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .cs_n(link.cs_n), .wr_n(link.wr_n), .rd_n(link.rd_n),
    .cal_n(link.cal_n), .offset_null_request_n(link.offset_null_request_n),
    .eoc(link.eoc), .int_n(link.int_n), .bus_oe_n(link.bus_oe_n),
    .result_bus(link.result_bus));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic code_type expect_code(input int s, input int c);
    int d;
    d = s - c;
    if (d > 4095) d = 4095;
    if (d < -4096) d = -4096;
    return code_type'(d);
  endfunction : expect_code
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // cs, wr, rd, cal of the bare device, then k falling edges
  task automatic pins(input logic [3:0] v, input int k);
    {link_b.cs_n, link_b.wr_n, link_b.rd_n, link_b.cal_n} = v;
    repeat (k) @(negedge ref_clk);
  endtask : pins
  // first edge always passes so a strobe is never set twice at one time
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_ready
  task automatic req(input logic [3:0] v);
    wait_ready();
    {start_req, cal_req, read_req, null_offset} = v;
    @(negedge ref_clk);
    {start_req, cal_req, read_req} = 3'b000;
  endtask : req
  task automatic wait_low(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b0 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_low
  // offset moves every time; only a null or a calibration may pick it up
  task automatic convert(input logic z);
    wait_ready();
    lfsr = lfsr_next(lfsr);
    sample = lfsr[12:0];
    offset = lfsr[25:13];
    if (z) begin
      corr = offset;
    end
    req({1'b1, 2'b00, z});
    // a ready left from an unread result stands a few clocks after the start
    repeat (4) @(negedge ref_clk);
    wait_low(link.int_n, 200);
    check(13'(link.eoc), 13'h0001);
    req(4'b0010);
    wait_low(result_strobe, 1);
    while (result_strobe !== 1'b1 && cycles < 19000) @(negedge ref_clk);
    check(result_data, expect_code(sample, corr));
    check(13'(link.int_n), 13'h0001);
  endtask : convert
  task automatic bare_device();
    int n;
    pins(4'b0011, 4);
    pins(4'b0111, 2);
    pins(4'b1111, 1);
    n = 8;
    while (link_b.eoc !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    check(13'(n >= CAL - 2), 13'h0001);
    pins(4'b1111, 40);
    check(13'(link_b.int_n), 13'h0001);
    pins(4'b0110, 5);
    check(link_b.bus_oe_n, ~`TEST_MASK);
    pins(4'b1111, 5);
    check(link_b.bus_oe_n, 13'h1fff);
    lfsr = lfsr_next(lfsr);
    sample_b = lfsr[12:0];
    pins(4'b0011, 3);
    pins(4'b0111, 1);
    pins(4'b1111, 5);
    check(13'(track_b), 13'h0001);
    pins(4'b1111, 9);
    check(13'(link_b.eoc), 13'h0000);
    lfsr = lfsr_next(lfsr);
    sample_b = lfsr[20:8];
    pins(4'b0011, 5);
    check(13'(link_b.eoc), 13'h0001);
    // an abort mid-conversion may spoil the corrections: recalibrate first
    pins(4'b1110, 3);
    pins(4'b1111, 50);
    pins(4'b0011, 3);
    pins(4'b0111, 1);
    pins(4'b1111, 0);
    wait_low(link_b.int_n, 100);
    pins(4'b1110, 3);
    pins(4'b1111, 2);
    check(13'(link_b.int_n), 13'h0001);
    pins(4'b1111, 45);
    pins(4'b0101, 5);
    check(link_b.result_bus, expect_code(sample_b, 5));
    pins(4'b1111, 4);
    check(13'(link_b.int_n), 13'h0001);
  endtask : bare_device
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    {link_b.cs_n, link_b.wr_n, link_b.rd_n, link_b.cal_n} = 4'hf;
    link_b.offset_null_request_n = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    bare_device();
    for (int i = 0; i < 12; i++) begin
      convert(i[0]);
    end
    req(4'b1000);
    convert(1'b0);
    wait_ready();
    lfsr = lfsr_next(lfsr);
    offset = lfsr[12:0];
    corr = offset;
    req(4'b0100);
    convert(1'b0);
    conclude();
  end
endmodule : tb_sar_adc_control_sequencer
